//--- i2c_status_flags_test.sv
/*
 * Self-checking bench for the status flag block.
 * Assumes the design, checker and far-side model compile alongside.
 */
`timescale 1ns/1ps
`include "i2cst_defs.svh"

module i2c_status_flags_test
	import i2cst_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, module_busy, tx_taken, pready, pslverr;
	logic tx_full, rx_full, irq, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [7:0] tx_byte;
	i2cst_evt_t evt;
	i2cst_flags_t flags;
	int err_count = 0;
	int comparisons = 0;
	// Rows applied in order; each expectation builds on the one above
	i2cst_evt_t ev[10] = '{19'h10000, 19'h60000, 19'h40000, 19'h08000, 19'h04000,
		19'h02000, 19'h00800, 19'h01000, 19'h00200, 19'h00400};
	logic [8:0] fx[10] = '{9'h080, 9'h100, 9'h000, 9'h040, 9'h060,
		9'h070, 9'h072, 9'h070, 9'h041, 9'h040};
	always #12.5 pclk = ~pclk;
	i2cst_status i2cst_status_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
		.module_busy(module_busy), .tx_taken(tx_taken), .tx_byte(tx_byte), .tx_full(tx_full),
		.rx_full(rx_full), .flags(flags), .irq(irq));
	i2cst_bus_model i2cst_bus_model_inst (.pclk(pclk), .evt(evt));
	task give_verdict;
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Waits on pready under a bound; the slave's latency is not assumed
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			give_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	initial begin
		{presetn, psel, penable, pwrite, module_busy, tx_taken} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check(flags, 32'h0);
		apb(1'b0, `I2CST_OFS_STATUS, 32'h0);
		check(rd, 32'h0);
		for (int i = 0; i < 10; i++) begin
			i2cst_bus_model_inst.send(ev[i]);
			@(negedge pclk);
			check(flags, fx[i]);
		end
		apb(1'b0, `I2CST_OFS_STATUS, 32'h0);
		check(rd, 32'h400);
		i2cst_bus_model_inst.send(19'h04000);
		apb(1'b1, `I2CST_OFS_STATUS, 32'hFFFF);
		apb(1'b0, `I2CST_OFS_STATUS, 32'h0);
		check(rd, 32'h200);
		module_busy <= 1'b1;
		apb(1'b1, `I2CST_OFS_TXBUF, 32'h3C);
		module_busy <= 1'b0;
		apb(1'b0, `I2CST_OFS_STATUS, 32'h0);
		check(rd, 32'h280);
		apb(1'b1, `I2CST_OFS_STATUS, 32'h80);
		apb(1'b0, `I2CST_OFS_STATUS, 32'h0);
		check(rd, 32'h200);
		i2cst_bus_model_inst.send(19'h001A5);
		i2cst_bus_model_inst.send(19'h0015A);
		apb(1'b0, `I2CST_OFS_STATUS, 32'h0);
		check(rd, 32'h240);
		apb(1'b0, `I2CST_OFS_RXBUF, 32'h0);
		check(rd, 32'hA5);
		check(irq, 32'h0);
		apb(1'b1, `I2CST_OFS_MASK, 32'h40);
		@(negedge pclk);
		check(irq, 32'h1);
		apb(1'b1, `I2CST_OFS_STATUS, 32'h40);
		@(negedge pclk);
		check(irq, 32'h0);
		apb(1'b0, 12'h018, 32'h0);
		check(er, 32'h1);
		// Buffer fill, reject while full, release by the engine
		apb(1'b1, `I2CST_OFS_TXBUF, 32'h5A);
		@(negedge pclk);
		check({tx_full, tx_byte}, 32'h15A);
		apb(1'b1, `I2CST_OFS_TXBUF, 32'hA5);
		apb(1'b0, `I2CST_OFS_STATUS, 32'h0);
		check(rd, 32'h280);
		tx_taken <= 1'b1;
		@(posedge pclk);
		tx_taken <= 1'b0;
		@(negedge pclk);
		check({rx_full, tx_full, tx_byte}, 32'h05A);
		apb(1'b0, `I2CST_OFS_EVENT, 32'h0);
		check(rd, 32'h3F);
		check(er, 32'h0);
		apb(1'b1, `I2CST_OFS_EVMASK, 32'h1);
		@(negedge pclk);
		check(irq, 32'h1);
		// Mid-run reset with two flags, all six events and one bit of each mask set
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		check({flags, tx_full, rx_full, irq}, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `I2CST_OFS_EVENT, 32'h0);
		check(rd, 32'h0);
		give_verdict();
	end
endmodule : i2c_status_flags_test

//--- i2cst_bus_model.sv
/*
 * Far-side model: bus conditions seen by the engine, as event pulses.
 * Assumes calls start right after a rising edge of pclk.
 */
`timescale 1ns/1ps

module i2cst_bus_model
	import i2cst_pkg::*;
(
	// Clock and events
	input wire logic pclk,
	output i2cst_evt_t evt
);
	initial evt = '0;
	task send(input i2cst_evt_t e);
		@(posedge pclk);
		evt <= e;
		@(posedge pclk);
		evt <= '0;
	endtask : send
endmodule : i2cst_bus_model

//--- i2cst_defs.svh
/*
 * Register offsets, field positions, reset values and clock figures for the
 * two-wire status flag block.
 * Assumes inclusion by bare name from the bench, the status block and the checker.
 */
`ifndef I2CST_DEFS_SVH
`define I2CST_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define I2CST_OFS_STATUS 12'h000
`define I2CST_OFS_MASK 12'h004
`define I2CST_OFS_TXBUF 12'h008
`define I2CST_OFS_RXBUF 12'h00C
`define I2CST_OFS_EVENT 12'h010
`define I2CST_OFS_EVMASK 12'h014

// ****************************************
// Status field positions
// ****************************************
`define I2CST_BIT_ACK 15
`define I2CST_BIT_TXP 14
`define I2CST_BIT_COL 10
`define I2CST_BIT_GC 9
`define I2CST_BIT_TEN 8
`define I2CST_BIT_WCOL 7
`define I2CST_BIT_OV 6
`define I2CST_BIT_DA 5
`define I2CST_BIT_STOP 4
`define I2CST_CLR_MASK 16'h04C0

// ****************************************
// Event register bits
// ****************************************
`define I2CST_EV_COL 0
`define I2CST_EV_WCOL 1
`define I2CST_EV_OV 2
`define I2CST_EV_STOP 3
`define I2CST_EV_RX 4
`define I2CST_EV_W 5

// ****************************************
// Reset values and clock
// ****************************************
`define I2CST_RST_STATUS 16'h0000
`define I2CST_RST_BYTE 8'h00
`define I2CST_CLK_HZ 40000000

`endif

//--- i2cst_pkg.sv
/*
 * Types for the two-wire status flag block.
 * Assumes the defs header is on the include path.
 */
package i2cst_pkg;

	// ****************************************
	// Protocol engine event bundle
	// ****************************************
	typedef struct packed {
		logic ack_slot_end;
		logic ack_nack;
		logic tx_start;
		logic collision;
		logic gc_match;
		logic ten_bit_match;
		logic addr_match;
		logic data_byte;
		logic start_det;
		logic stop_det;
		logic rx_load;
		logic [7:0] rx_byte;
	} i2cst_evt_t;

	typedef struct packed {
		logic ack_result_flag;
		logic tx_in_progress_flag;
		logic collision_flag;
		logic general_call_flag;
		logic ten_bit_match_flag;
		logic write_collision_flag;
		logic rx_overflow_flag;
		logic data_flag;
		logic stop_flag;
	} i2cst_flags_t;

endpackage : i2cst_pkg

//--- i2cst_status.sv
/*
 * Status flag logic of a two-wire bus controller, with APB slave, transmit
 * and receive buffers and a masked event interrupt.
 * Assumes a protocol engine that pulses the event bundle for one pclk each,
 * and an APB master that holds a request until pready.
 */
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "i2cst_defs.svh"

module i2cst_status
	import i2cst_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Protocol engine
	input wire i2cst_evt_t evt,
	input wire logic module_busy,
	input wire logic tx_taken,
	output logic [7:0] tx_byte,
	output logic tx_full,
	output logic rx_full,
	output i2cst_flags_t flags,
	// Interrupt
	output logic irq
);

	// Offsets up to the event mask need five address bits
	if (ADDR_W < 5) begin : g_addr_w_check
		$error("ADDR_W too small for the register map");
	end

	// ****************************************
	// Bus decode
	// ****************************************
	logic [15:0] stat_q, stat_d;
	logic [15:0] mask_q;
	logic [5:0] ev_q;
	wire logic [5:0] ev_d;
	logic [5:0] evmask_q;
	logic [7:0] txbuf_q, rxbuf_q;
	logic txf_q, rxf_q;
	logic [11:0] addr12;
	logic acc, wr, rd, lo_en;
	logic sel_stat, sel_mask, sel_tx, sel_rx, sel_ev, sel_evm, hit;
	logic tx_wr, tx_reject, rx_read, ov_evt;
	logic [15:0] clr_stat;
	logic [5:0] clr_ev, set_ev;

	assign addr12 = 12'(paddr);
	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign lo_en = pstrb[0];
	assign sel_stat = (addr12 == `I2CST_OFS_STATUS);
	assign sel_mask = (addr12 == `I2CST_OFS_MASK);
	assign sel_tx = (addr12 == `I2CST_OFS_TXBUF);
	assign sel_rx = (addr12 == `I2CST_OFS_RXBUF);
	assign sel_ev = (addr12 == `I2CST_OFS_EVENT);
	assign sel_evm = (addr12 == `I2CST_OFS_EVMASK);
	assign hit = sel_stat | sel_mask | sel_tx | sel_rx | sel_ev | sel_evm;
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;

	assign tx_wr = wr & sel_tx & lo_en;
	assign tx_reject = tx_wr & (module_busy | txf_q);
	assign rx_read = rd & sel_rx;
	assign ov_evt = evt.rx_load & rxf_q & ~rx_read;

	assign clr_stat = (wr & sel_stat) ?
		(pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}} & `I2CST_CLR_MASK) : 16'h0000;

	// ****************************************
	// Status next value
	// ****************************************
	always_comb begin
		stat_d = stat_q;
		stat_d = stat_d & ~clr_stat;
		if (evt.ack_slot_end) begin
			stat_d[`I2CST_BIT_ACK] = evt.ack_nack;
		end
		if (evt.ack_slot_end) begin
			stat_d[`I2CST_BIT_TXP] = 1'b0;
		end
		if (evt.tx_start) begin
			stat_d[`I2CST_BIT_TXP] = 1'b1;
		end
		if (evt.collision) begin
			stat_d[`I2CST_BIT_COL] = 1'b1;
		end
		if (evt.stop_det) begin
			stat_d[`I2CST_BIT_GC] = 1'b0;
			stat_d[`I2CST_BIT_TEN] = 1'b0;
		end
		if (evt.gc_match) begin
			stat_d[`I2CST_BIT_GC] = 1'b1;
		end
		if (evt.ten_bit_match) begin
			stat_d[`I2CST_BIT_TEN] = 1'b1;
		end
		if (tx_reject) begin
			stat_d[`I2CST_BIT_WCOL] = 1'b1;
		end
		if (ov_evt) begin
			stat_d[`I2CST_BIT_OV] = 1'b1;
		end
		if (evt.addr_match) begin
			stat_d[`I2CST_BIT_DA] = 1'b0;
		end else if (evt.data_byte) begin
			stat_d[`I2CST_BIT_DA] = 1'b1;
		end
		if (evt.stop_det) begin
			stat_d[`I2CST_BIT_STOP] = 1'b1;
		end else if (evt.start_det) begin
			stat_d[`I2CST_BIT_STOP] = 1'b0;
		end
		stat_d[13:11] = 3'h0;
		stat_d[3:0] = 4'h0;
	end

	// ****************************************
	// Event sticky bits
	// ****************************************
	assign set_ev = {tx_reject, evt.rx_load, evt.stop_det, ov_evt, tx_reject, evt.collision};
	assign clr_ev = (wr & sel_ev & lo_en) ? pwdata[5:0] : 6'h00;

	// Set wins over clear so no event is lost
	for (genvar b = 0; b < 6; b++) begin : g_ev
		if (b == `I2CST_EV_W) begin : g_copy
			// Mirror of write collision; it clears together with it
			assign ev_d[b] = ev_d[`I2CST_EV_WCOL];
		end else begin : g_sticky
			assign ev_d[b] = (ev_q[b] & ~clr_ev[b]) | set_ev[b];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= `I2CST_RST_STATUS;
			ev_q <= 6'h00;
		end else begin
			stat_q <= stat_d;
			ev_q <= ev_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= 16'h0000;
			evmask_q <= 6'h00;
		end else begin
			if (wr & sel_mask) begin
				mask_q <= pwdata[15:0] & `I2CST_CLR_MASK;
			end
			if (wr & sel_evm & lo_en) begin
				evmask_q <= pwdata[5:0];
			end
		end
	end

	// ****************************************
	// Buffers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txbuf_q <= `I2CST_RST_BYTE;
			txf_q <= 1'b0;
		end else begin
			if (tx_wr & ~tx_reject) begin
				txbuf_q <= pwdata[7:0];
				txf_q <= 1'b1;
			end else if (tx_taken) begin
				txf_q <= 1'b0;
			end
		end
	end

	// Overflowing byte is dropped; the unread byte is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxbuf_q <= `I2CST_RST_BYTE;
			rxf_q <= 1'b0;
		end else begin
			if (evt.rx_load & ~ov_evt) begin
				rxbuf_q <= evt.rx_byte;
				rxf_q <= 1'b1;
			end else if (rx_read) begin
				rxf_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// Read mux and outputs
	// ****************************************
	logic [31:0] rdata_sel;
	assign rdata_sel = sel_stat ? {16'h0000, stat_q} :
		sel_mask ? {16'h0000, mask_q} :
		sel_tx ? {24'h000000, txbuf_q} :
		sel_rx ? {24'h000000, rxbuf_q} :
		sel_ev ? {26'h0000000, ev_q} :
		sel_evm ? {26'h0000000, evmask_q} : 32'h00000000;
	assign prdata = rd ? rdata_sel : 32'h00000000;

	assign tx_byte = txbuf_q;
	assign tx_full = txf_q;
	assign rx_full = rxf_q;
	assign irq = (|(stat_q & mask_q)) | (|(ev_q & evmask_q));

	assign flags.ack_result_flag = stat_q[`I2CST_BIT_ACK];
	assign flags.tx_in_progress_flag = stat_q[`I2CST_BIT_TXP];
	assign flags.collision_flag = stat_q[`I2CST_BIT_COL];
	assign flags.general_call_flag = stat_q[`I2CST_BIT_GC];
	assign flags.ten_bit_match_flag = stat_q[`I2CST_BIT_TEN];
	assign flags.write_collision_flag = stat_q[`I2CST_BIT_WCOL];
	assign flags.rx_overflow_flag = stat_q[`I2CST_BIT_OV];
	assign flags.data_flag = stat_q[`I2CST_BIT_DA];
	assign flags.stop_flag = stat_q[`I2CST_BIT_STOP];

endmodule : i2cst_status

//--- i2cst_status_assertions.sv
/*
 * Concurrent checks on the status flag block.
 * Assumes binding to i2cst_status, whose ports it watches.
 */
`timescale 1ns/1ps
`include "i2cst_defs.svh"

module i2cst_status_chk
	import i2cst_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus and engine
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire i2cst_evt_t evt,
	input wire logic module_busy,
	input wire i2cst_flags_t flags
);
	logic acc;
	assign acc = psel && penable;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************************************
	// Flag updates
	// ****************************************
	property p_ack; evt.ack_slot_end |=> flags.ack_result_flag == $past(evt.ack_nack); endproperty
	a_ack: assert property (p_ack) else $error("ack flag wrong");
	property p_txp_set; evt.tx_start |=> flags.tx_in_progress_flag; endproperty
	a_txp_set: assert property (p_txp_set) else $error("tx flag not set");
	property p_txp_clr; evt.ack_slot_end && !evt.tx_start |=> !flags.tx_in_progress_flag; endproperty
	a_txp_clr: assert property (p_txp_clr) else $error("tx flag not cleared");
	property p_col; evt.collision |=> flags.collision_flag; endproperty
	a_col: assert property (p_col) else $error("collision flag not set");
	property p_gc; evt.stop_det && !evt.gc_match |=> !flags.general_call_flag; endproperty
	a_gc: assert property (p_gc) else $error("general call flag kept");
	property p_ten; evt.ten_bit_match |=> flags.ten_bit_match_flag; endproperty
	a_ten: assert property (p_ten) else $error("ten bit flag not set");
	property p_wcol;
		acc && pwrite && pstrb[0] && paddr == `I2CST_OFS_TXBUF && module_busy
			|=> flags.write_collision_flag;
	endproperty
	a_wcol: assert property (p_wcol) else $error("write collision missed");
	property p_da; evt.addr_match |=> !flags.data_flag; endproperty
	a_da: assert property (p_da) else $error("data flag not cleared");
	property p_stop; evt.start_det && !evt.stop_det |=> !flags.stop_flag; endproperty
	a_stop: assert property (p_stop) else $error("stop flag kept");
	property p_zero; acc && !pwrite && paddr == `I2CST_OFS_STATUS |-> prdata[13:11] == 3'h0; endproperty
	a_zero: assert property (p_zero) else $error("unused bits nonzero");
	cover property (evt.stop_det ##1 flags.stop_flag);
	cover property (acc && pwrite && module_busy);
	cover property (evt.rx_load ##1 flags.rx_overflow_flag);
endmodule : i2cst_status_chk

bind i2cst_status i2cst_status_chk #(.ADDR_W(ADDR_W)) i2cst_status_chk_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pstrb(pstrb), .prdata(prdata), .evt(evt), .module_busy(module_busy), .flags(flags));
